// file: design/sbf_serial_buffers.sv
// Serial receive and transmit buffers with flow control and packetizing
//
// Notes on behaviour
// - Full receive buffer discards new host bytes.
// - Radio packet without room dropped whole.
// - CTS goes high at threshold level.
// - CTS low again at threshold minus 17.
// - RTS high holds transmit data back.
// - No characters offered once RTS is high.
// - Data present line low when UART output queued.
// - Separate RTS/CTS enables, UART only.
// - Packetize after idle timeout; zero immediate.
// - Escape sequence packetizes bytes before it.
// - Packetize when maximum payload is buffered.
// - No transparent mode on SPI.
// - With both ports enabled, first port with input owns until reset.
`timescale 1ns/1ps
`default_nettype none

module sbf_serial_buffers import sbf_pkg::*; #(
    parameter int RXB_DEPTH = 256,
    parameter int TXB_DEPTH = 256,
    parameter int MAX_PAYLOAD = 256
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Configuration
    input wire sbf_cfg_t cfg,
    // Bytes from the host
    input wire logic uart_rx_valid,
    input wire logic [7:0] uart_rx_data,
    input wire logic spi_rx_valid,
    input wire logic [7:0] spi_rx_data,
    // Flow control and indicators
    input wire logic rts_n,
    output logic cts_n,
    output logic data_present_line_n,
    output logic attention_line_n,
    // Bytes to the host
    output logic host_tx_valid,
    output logic [7:0] host_tx_data,
    output logic host_tx_spi,
    input wire logic host_tx_ready,
    // Receive buffer drain toward the packet engine
    output logic eng_valid,
    output logic [7:0] eng_data,
    input wire logic eng_ready,
    // Packetize requests
    output logic pkt_req,
    output logic [15:0] pkt_len,
    output logic cmd_seq_done,
    // Radio packets toward the transmit buffer
    input wire logic rf_start,
    input wire logic [15:0] rf_len,
    input wire logic rf_valid,
    input wire logic [7:0] rf_data,
    // Status
    output logic rf_drop,
    output logic rx_overflow,
    output logic [1:0] active_port
);

    localparam int RAW = $clog2(RXB_DEPTH);
    localparam int TAW = $clog2(TXB_DEPTH);
    localparam logic [16:0] RXB_FULL = 17'(RXB_DEPTH);
    localparam logic [16:0] TXB_FULL = 17'(TXB_DEPTH);
    localparam logic [16:0] MAX_PL = 17'(MAX_PAYLOAD);

    // Port selection
    sbf_port_t port_q; // Latched port
    sbf_port_t port_sel; // Port in force
    logic in_uart; // UART byte taken
    logic in_spi; // SPI byte taken
    logic in_valid; // Any byte taken
    logic [7:0] in_byte; // Byte taken
    logic out_uart; // Output to UART

    // Receive buffer state
    logic [16:0] rxc_q; // Occupancy
    logic [RAW-1:0] rx_wp_q; // Write pointer
    logic [RAW-1:0] rx_rp_q; // Read pointer
    logic rx_wr; // Store byte
    logic rx_rd; // Fetch byte
    logic eng_valid_q; // Engine byte held

    // Transmit buffer state
    logic [16:0] txc_q; // Occupancy
    logic [16:0] remain_q; // Bytes due in packet
    logic [TAW-1:0] tx_wp_q; // Write pointer
    logic [TAW-1:0] tx_rp_q; // Read pointer
    logic tx_wr; // Store radio byte
    logic tx_rd; // Fetch byte
    logic tx_valid_q; // Host byte held
    logic tx_stall; // Host pause

    // Packetizing state
    logic transp; // Transparent in force
    logic [16:0] pend_q; // Bytes not packetized
    logic [16:0] mark_q; // Pending before escape
    logic [TIMER_W-1:0] idle_q; // Idle cycles
    logic [TIMER_W-1:0] to_cyc; // Timeout cycles
    logic [TIMER_W-1:0] gt_cyc; // Guard cycles
    sbf_esc_t esc_q; // Escape state
    logic [1:0] esc_cnt_q; // Escape chars seen
    logic esc_fire; // Sequence complete
    logic fire; // Packetize now
    logic [16:0] fire_len; // Packet length
    logic [16:0] pend_sub; // Bytes leaving pending

    // Port choice; first input decides when both enabled
    always_comb begin
        port_sel = port_q;
        if (port_q == PORT_NONE) begin
            if (cfg.uart_port_en && cfg.spi_port_en) begin
                if (uart_rx_valid) begin
                    port_sel = PORT_UART;
                end else if (spi_rx_valid) begin
                    port_sel = PORT_SPI;
                end
            end else if (cfg.spi_port_en) begin
                port_sel = PORT_SPI;
            end else begin
                // Neither or only UART enabled falls back to the UART
                port_sel = PORT_UART;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_q <= PORT_NONE;
        end else begin
            port_q <= port_sel;
        end
    end

    // Input from the unselected port is ignored
    assign in_uart = uart_rx_valid && (port_sel == PORT_UART);
    assign in_spi = spi_rx_valid && (port_sel == PORT_SPI);
    assign in_valid = in_uart || in_spi;
    assign in_byte = in_uart ? uart_rx_data : spi_rx_data;
    assign out_uart = (port_sel != PORT_SPI);
    assign active_port = port_q;

    // store only while there is room
    assign rx_wr = in_valid && (rxc_q < RXB_FULL);
    // Read a byte when the engine output is free or being taken
    assign rx_rd = (rxc_q != 17'h0) && (!eng_valid_q || eng_ready);
    assign eng_valid = eng_valid_q;

    // Receive buffer memory
    sbf_buf_mem #(.DW(8), .DEPTH(RXB_DEPTH)) u_rx_mem (
        .clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(rx_wr),
        .wr_addr(rx_wp_q),
        .wr_data(in_byte),
        .rd_en(rx_rd),
        .rd_addr(rx_rp_q),
        .rd_data(eng_data)
    );

    // Receive pointers, occupancy and overflow pulse
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxc_q <= '0;
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            eng_valid_q <= 1'b0;
            rx_overflow <= 1'b0;
        end else begin
            rxc_q <= rxc_q + 17'(rx_wr) - 17'(rx_rd);
            if (rx_wr) begin
                rx_wp_q <= rx_wp_q + 1'b1;
            end
            if (rx_rd) begin
                rx_rp_q <= rx_rp_q + 1'b1;
                eng_valid_q <= 1'b1;
            end else if (eng_ready) begin
                eng_valid_q <= 1'b0;
            end
            rx_overflow <= in_valid && !rx_wr;
        end
    end

    // CTS with hysteresis, active only on the UART
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cts_n <= CTS_N_RESET;
        end else if (!cfg.cts_enable_setting || !out_uart) begin
            // no CTS without its enable or on SPI
            cts_n <= 1'b0;
        end else if (rxc_q >= {1'b0, cfg.flow_threshold_setting}) begin
            // stop the host at the threshold
            cts_n <= 1'b1;
        end else if (rxc_q + CTS_HYSTERESIS <= {1'b0, cfg.flow_threshold_setting}) begin
            // resume once the level falls far enough
            cts_n <= 1'b0;
        end
    end

    // transparent packetizing only on the UART
    assign transp = cfg.transparent_mode && (port_sel == PORT_UART);
    assign to_cyc = TIMER_W'(32'(cfg.packetize_timeout_setting) * SETTING_UNIT_CYC);
    assign gt_cyc = TIMER_W'(32'(cfg.guard_time) * SETTING_UNIT_CYC);

    // Idle timer, cleared by each host byte and saturating
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_q <= '0;
        end else if (in_valid) begin
            idle_q <= '0;
        end else if (idle_q != TIMER_MAX) begin
            idle_q <= idle_q + 1'b1;
        end
    end

    // Escape detector: guard, three characters, guard
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            esc_q <= ESC_IDLE;
            esc_cnt_q <= '0;
            mark_q <= '0;
        end else begin
            case (esc_q)
                ESC_IDLE: begin
                    // Leading guard must have passed before the first character
                    if (transp && rx_wr && in_byte == cfg.escape_character
                            && idle_q >= gt_cyc) begin
                        esc_q <= ESC_CHARS;
                        esc_cnt_q <= 2'h1;
                        mark_q <= pend_q - pend_sub;
                    end
                end
                ESC_CHARS: begin
                    if (in_valid) begin
                        if (rx_wr && in_byte == cfg.escape_character) begin
                            esc_cnt_q <= esc_cnt_q + 1'b1;
                            if (esc_cnt_q + 1'b1 == ESC_CHAR_COUNT) begin
                                esc_q <= ESC_POST;
                            end
                        end else begin
                            // Any other byte makes the run ordinary data
                            esc_q <= ESC_IDLE;
                        end
                    end
                end
                ESC_POST: begin
                    // Trailing guard; a byte inside it aborts
                    if (in_valid || esc_fire) begin
                        esc_q <= ESC_IDLE;
                    end
                end
                default: begin
                    esc_q <= ESC_IDLE;
                end
            endcase
        end
    end

    // sequence completes when the trailing guard expires
    assign esc_fire = (esc_q == ESC_POST) && !in_valid && (idle_q >= gt_cyc) && transp;

    // Packetize decision, escape first, then size, then idle
    always_comb begin
        fire = 1'b0;
        fire_len = '0;
        pend_sub = '0;
        if (esc_fire) begin
            // send what was buffered before the sequence
            fire = (mark_q != 17'h0);
            fire_len = mark_q;
            pend_sub = mark_q + 17'(ESC_CHAR_COUNT);
        end else if (transp && esc_q == ESC_IDLE) begin
            if (pend_q >= MAX_PL) begin
                fire = 1'b1;
                fire_len = MAX_PL;
                pend_sub = MAX_PL;
            end else if (pend_q != 17'h0 && (to_cyc == '0 || idle_q >= to_cyc)) begin
                // idle timeout, zero means right away
                fire = 1'b1;
                fire_len = pend_q;
                pend_sub = pend_q;
            end
        end
    end

    // Pending count and packetize outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
            pkt_req <= 1'b0;
            pkt_len <= '0;
            cmd_seq_done <= 1'b0;
        end else begin
            pend_q <= transp ? (pend_q - pend_sub + 17'(rx_wr)) : '0;
            pkt_req <= fire;
            if (fire) begin
                pkt_len <= fire_len[15:0];
            end
            cmd_seq_done <= esc_fire;
        end
    end

    // accept a radio packet only if all of it fits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            remain_q <= '0;
            rf_drop <= 1'b0;
        end else begin
            rf_drop <= 1'b0;
            if (rf_start && remain_q == 17'h0) begin
                if (rf_len != 16'h0 && txc_q + {1'b0, rf_len} <= TXB_FULL) begin
                    remain_q <= {1'b0, rf_len};
                end else begin
                    rf_drop <= 1'b1;
                end
            end else if (rf_start) begin
                // A start during an accepted packet is dropped
                rf_drop <= 1'b1;
            end else if (tx_wr) begin
                remain_q <= remain_q - 17'h1;
            end
        end
    end

    // Radio bytes are stored only inside an accepted packet
    assign tx_wr = rf_valid && (remain_q != 17'h0) && !rf_start;

    // RTS pause, only with its enable and on the UART
    assign tx_stall = cfg.rts_enable_setting && out_uart && rts_n;
    assign tx_rd = (txc_q != 17'h0) && (!tx_valid_q || host_tx_ready) && !tx_stall;
    // a byte already fetched waits rather than being sent late
    assign host_tx_valid = tx_valid_q && !tx_stall;
    assign host_tx_spi = (port_q == PORT_SPI);

    // Transmit buffer memory
    sbf_buf_mem #(.DW(8), .DEPTH(TXB_DEPTH)) u_tx_mem (
        .clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(tx_wr),
        .wr_addr(tx_wp_q),
        .wr_data(rf_data),
        .rd_en(tx_rd),
        .rd_addr(tx_rp_q),
        .rd_data(host_tx_data)
    );

    // Transmit pointers and occupancy
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            txc_q <= '0;
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            tx_valid_q <= 1'b0;
        end else begin
            txc_q <= txc_q + 17'(tx_wr) - 17'(tx_rd);
            if (tx_wr) begin
                tx_wp_q <= tx_wp_q + 1'b1;
            end
            if (tx_rd) begin
                tx_rp_q <= tx_rp_q + 1'b1;
                tx_valid_q <= 1'b1;
            end else if (host_tx_valid && host_tx_ready) begin
                tx_valid_q <= 1'b0;
            end
        end
    end

    // Queued-output indicators toward the host
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_present_line_n <= INDICATOR_N_RESET;
            attention_line_n <= INDICATOR_N_RESET;
        end else begin
            // low while UART output is queued
            data_present_line_n <= !(cfg.data_present_en && out_uart
                && (txc_q != 17'h0 || tx_valid_q));
            attention_line_n <= !(!out_uart && (txc_q != 17'h0 || tx_valid_q));
        end
    end

endmodule

`default_nettype wire

// file: design/sbf_pkg.sv
// Shared constants, enumerations and carrier types for the serial buffer block
package sbf_pkg;

    // Clock period of ref_clk in nanoseconds
    localparam int CLK_PERIOD_NS = 40;
    // One unit of the timeout and guard settings, in nanoseconds
    localparam int SETTING_UNIT_NS = 1000;
    // Clock cycles per setting unit (rounded down, at least one)
    localparam int SETTING_UNIT_CYC = (SETTING_UNIT_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (SETTING_UNIT_NS / CLK_PERIOD_NS);

    // Hysteresis between flow-off and flow-on receive levels, in bytes
    localparam logic [16:0] CTS_HYSTERESIS = 17'h00011;
    // Number of escape characters in the command sequence
    localparam logic [1:0] ESC_CHAR_COUNT = 2'h3;
    // Width of the idle and guard timers
    localparam int TIMER_W = 24;
    // Saturation value of the idle timer
    localparam logic [TIMER_W-1:0] TIMER_MAX = 24'hffffff;

    // Reset values of the flow and indicator outputs
    localparam logic CTS_N_RESET = 1'b0;
    localparam logic INDICATOR_N_RESET = 1'b1;

    // Serial port selection state
    typedef enum logic [1:0] {
        PORT_NONE = 2'b00,
        PORT_UART = 2'b01,
        PORT_SPI  = 2'b10
    } sbf_port_t;

    // Command escape detector state
    typedef enum logic [1:0] {
        ESC_IDLE  = 2'b00,
        ESC_CHARS = 2'b01,
        ESC_POST  = 2'b10
    } sbf_esc_t;

    // Configuration settings, held steady by the host logic
    typedef struct packed {
        logic uart_port_en; // UART port enabled
        logic spi_port_en; // SPI port enabled
        logic rts_enable_setting; // Honour host RTS
        logic cts_enable_setting; // Drive CTS
        logic data_present_en; // Drive data present line
        logic transparent_mode; // Transparent, not framed
        logic [15:0] flow_threshold_setting; // Level that turns CTS off
        logic [15:0] packetize_timeout_setting; // Idle time to packetize
        logic [15:0] guard_time; // Silence around escape
        logic [7:0] escape_character; // Escape character
    } sbf_cfg_t;

endpackage

// file: design/sbf_buf_mem.sv
// Byte buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module sbf_buf_mem #(
    parameter int DW = 8,
    parameter int DEPTH = 256
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    // Read port
    input wire logic rd_en,
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    // Storage array, no reset needed
    logic [DW-1:0] mem_q [DEPTH];

    // Write side
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // Read data register holds until the next read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem_q[rd_addr];
        end
    end

endmodule

`default_nettype wire

// file: bench/sbf_assertions.sv
// Port-level checker for the serial buffer block, bound to its top
`timescale 1ns/1ps
`default_nettype none

module sbf_chk import sbf_pkg::*; #(
    parameter int TXB_DEPTH = 256,
    parameter int MAX_PAYLOAD = 256
) (
    // Clock, reset and settings
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire sbf_cfg_t cfg,
    // Flow control and indicators
    input wire logic rts_n,
    input wire logic cts_n,
    input wire logic data_present_line_n,
    input wire logic host_tx_valid,
    // Packetizing and radio side
    input wire logic pkt_req,
    input wire logic [15:0] pkt_len,
    input wire logic rf_start,
    input wire logic [15:0] rf_len,
    input wire logic rf_drop,
    input wire logic [1:0] active_port
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Pause holds output back
    property p_rts_hold;
        cfg.rts_enable_setting && rts_n && active_port != PORT_SPI |-> !host_tx_valid;
    endproperty
    a_rts_hold: assert property (p_rts_hold) else $error("byte offered during pause");
    // CTS low when disabled
    property p_cts_off;
        !cfg.cts_enable_setting |-> !cts_n;
    endproperty
    a_cts_off: assert property (p_cts_off) else $error("cts high while disabled");
    // No CTS on SPI
    property p_cts_spi;
        (active_port == PORT_SPI) [*3] |-> !cts_n;
    endproperty
    a_cts_spi: assert property (p_cts_spi) else $error("cts high on spi");
    // Indicator idle when disabled
    property p_dp_off;
        !cfg.data_present_en |-> data_present_line_n;
    endproperty
    a_dp_off: assert property (p_dp_off) else $error("indicator low while disabled");
    // Indicator low with a byte waiting
    property p_dp_on;
        cfg.data_present_en && active_port != PORT_SPI && $past(host_tx_valid)
            && host_tx_valid |-> !data_present_line_n;
    endproperty
    a_dp_on: assert property (p_dp_on) else $error("indicator high with data queued");
    // Framed mode never packetizes
    property p_api_quiet;
        !cfg.transparent_mode |-> !pkt_req;
    endproperty
    a_api_quiet: assert property (p_api_quiet) else $error("packet request in framed mode");
    // No packetizing on SPI
    property p_spi_quiet;
        active_port == PORT_SPI && $past(active_port) == PORT_SPI |-> !pkt_req;
    endproperty
    a_spi_quiet: assert property (p_spi_quiet) else $error("packet request on spi");
    // Packet length within one payload
    property p_len;
        pkt_req |-> pkt_len != 16'h0000 && pkt_len <= MAX_PAYLOAD;
    endproperty
    a_len: assert property (p_len) else $error("packet length out of range");
    // Oversize packet dropped
    property p_big_drop;
        rf_start && rf_len > TXB_DEPTH |=> rf_drop;
    endproperty
    a_big_drop: assert property (p_big_drop) else $error("oversize packet not dropped");
    // Chosen port sticks until reset
    property p_port_keep;
        active_port != PORT_NONE |=> $stable(active_port);
    endproperty
    a_port_keep: assert property (p_port_keep) else $error("active port changed");
endmodule

bind sbf_serial_buffers sbf_chk #(.TXB_DEPTH(TXB_DEPTH), .MAX_PAYLOAD(MAX_PAYLOAD)) i_sbf_chk (
    .ref_clk, .rst_n, .cfg, .rts_n, .cts_n, .data_present_line_n, .host_tx_valid, .pkt_req,
    .pkt_len, .rf_start, .rf_len, .rf_drop, .active_port);

`default_nettype wire

// file: bench/sbf_host_model.sv
// Host processor model on the UART output side
`timescale 1ns/1ps
`default_nettype none

module sbf_host_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Test controls
    input wire logic pause,
    input wire logic slow,
    // Serial lines facing the block
    output logic rts_n,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    // Bytes taken from the block, in order
    logic [7:0] got [$];
    // Pacing toggle for a slow host
    logic tick_q;

    // Pause line and pacing
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rts_n <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            rts_n <= pause;
            tick_q <= ~tick_q;
        end
    end

    assign tx_ready = !slow || tick_q;

    // Record every byte handed over
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            got.delete();
        end else if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
    end
endmodule

`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for the serial buffer block
`timescale 1ns/1ps
`default_nettype none

module tb import sbf_pkg::*; ;
    // Clock, reset and settings
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    sbf_cfg_t cfg = '0;
    // Stimulus
    logic uart_rx_valid = 1'b0;
    logic spi_rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic eng_ready = 1'b0;
    logic rf_start = 1'b0;
    logic rf_valid = 1'b0;
    logic [15:0] rf_len = 16'h0000;
    logic [7:0] rf_data = 8'h00;
    logic pause = 1'b0;
    logic slow = 1'b0;
    // Design outputs
    logic rts_n, cts_n, data_present_line_n, attention_line_n, host_tx_valid, host_tx_spi;
    logic host_tx_ready, eng_valid, pkt_req, cmd_seq_done, rf_drop, rx_overflow;
    logic [7:0] host_tx_data, eng_data;
    logic [15:0] pkt_len, last_len;
    logic [1:0] active_port;
    // Tallies
    int err_total = 0;
    int samples_checked = 0;
    int pkt_n, cmd_n, drop_n, ovf_n;
    logic [7:0] eng_q [$];

    // Clock at 25 MHz
    initial forever #20 ref_clk = ~ref_clk;

    sbf_serial_buffers #(.RXB_DEPTH(64), .TXB_DEPTH(16), .MAX_PAYLOAD(8)) i_sbf_serial_buffers (
        .ref_clk, .rst_n, .cfg, .uart_rx_valid, .uart_rx_data(rx_data), .spi_rx_valid,
        .spi_rx_data(rx_data), .rts_n, .cts_n, .data_present_line_n, .attention_line_n,
        .host_tx_valid, .host_tx_data, .host_tx_spi, .host_tx_ready, .eng_valid, .eng_data,
        .eng_ready, .pkt_req, .pkt_len, .cmd_seq_done, .rf_start, .rf_len, .rf_valid, .rf_data,
        .rf_drop, .rx_overflow, .active_port);

    sbf_host_model i_sbf_host_model (.ref_clk, .rst_n, .pause, .slow, .rts_n,
        .tx_valid(host_tx_valid), .tx_data(host_tx_data), .tx_ready(host_tx_ready));

    // Count pulses and capture engine bytes
    always @(posedge ref_clk) begin
        if (eng_valid && eng_ready) eng_q.push_back(eng_data);
        if (pkt_req) last_len = pkt_len;
        pkt_n += pkt_req;
        cmd_n += cmd_seq_done;
        drop_n += rf_drop;
        ovf_n += rx_overflow;
    end

    // Compare one value
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Print the verdict and stop
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Settings: uart, spi, rts, cts, indicator, transparent
    function automatic sbf_cfg_t mk(input logic [5:0] f, input logic [15:0] to);
        return '{f[5], f[4], f[3], f[2], f[1], f[0], 16'h002f, to, 16'h0001, 8'h2b};
    endfunction

    // Reset for 16 cycles with new settings
    task automatic start(input sbf_cfg_t c);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        cfg <= c;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        eng_q.delete();
        pkt_n = 0;
        cmd_n = 0;
        drop_n = 0;
        ovf_n = 0;
    endtask

    // Wait at falling edges where outputs are settled
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Back-to-back host bytes on one port
    task automatic send(input logic spi, input int n, input logic [7:0] base);
        @(posedge ref_clk);
        for (int i = 0; i < n; i++) begin
            uart_rx_valid <= !spi;
            spi_rx_valid <= spi;
            rx_data <= base + 8'(i);
            @(posedge ref_clk);
        end
        uart_rx_valid <= 1'b0;
        spi_rx_valid <= 1'b0;
    endtask

    // One radio packet: start, then its bytes
    task automatic rf_pkt(input logic [15:0] len, input logic [7:0] base);
        @(posedge ref_clk);
        rf_start <= 1'b1;
        rf_len <= len;
        for (int i = 0; i < len; i++) begin
            @(posedge ref_clk);
            rf_start <= 1'b0;
            rf_valid <= 1'b1;
            rf_data <= base + 8'(i);
        end
        @(posedge ref_clk);
        rf_start <= 1'b0;
        rf_valid <= 1'b0;
    endtask

    // Bounded wait for a byte count at the engine or the host
    task automatic wait_n(input int want, input bit host);
        int seen;
        for (int i = 0; i < 400; i++) begin
            seen = host ? i_sbf_host_model.got.size() : eng_q.size();
            if (seen >= want) return;
            @(negedge ref_clk);
        end
        chk("byte wait", want[15:0], seen[15:0]);
        finish_test();
    endtask

    initial begin
        // Flow control and overflow; output register holds one byte more
        start(mk(6'b100100, 16'h0000));
        chk("cts reset", 1'b0, cts_n);
        send(1'b0, 65, 8'h00);
        send(1'b0, 1, 8'hee);
        idle(3);
        chk("cts off", 1'b1, cts_n);
        chk("overflow", 1, ovf_n);
        @(posedge ref_clk) eng_ready <= 1'b1;
        wait_n(24, 1'b0);
        @(posedge ref_clk) eng_ready <= 1'b0;
        idle(3);
        chk("cts held", 1'b1, cts_n);
        @(posedge ref_clk) eng_ready <= 1'b1;
        wait_n(65, 1'b0);
        idle(3);
        chk("cts on", 1'b0, cts_n);
        chk("rx count", 65, eng_q.size());
        chk("rx last", 8'h40, eng_q[64]);
        $display("flow done %0d", err_total);
        // Transmit side: pause, indicator, whole-packet drop
        @(posedge ref_clk) pause <= 1'b1;
        slow <= 1'b1;
        start(mk(6'b101010, 16'h0000));
        rf_pkt(3, 8'ha0);
        idle(10);
        chk("paused out", 0, i_sbf_host_model.got.size());
        chk("present", 1'b0, data_present_line_n);
        rf_pkt(14, 8'hb0);
        rf_pkt(13, 8'hc0);
        idle(2);
        chk("drop", 1, drop_n);
        @(posedge ref_clk) pause <= 1'b0;
        wait_n(16, 1'b1);
        idle(20);
        chk("tx count", 16, i_sbf_host_model.got.size());
        chk("tx first", 8'ha0, i_sbf_host_model.got[0]);
        chk("tx third", 8'hc0, i_sbf_host_model.got[3]);
        chk("present off", 1'b1, data_present_line_n);
        $display("transmit done %0d", err_total);
        // Packetizing
        @(posedge ref_clk) slow <= 1'b0;
        start(mk(6'b100001, 16'h0000));
        send(1'b0, 1, 8'h41);
        idle(5);
        chk("zero timeout", 1, pkt_n);
        chk("zero len", 16'h0001, last_len);
        start(mk(6'b100001, 16'h0002));
        send(1'b0, 3, 8'h50);
        idle(40);
        chk("early", 0, pkt_n);
        idle(20);
        chk("timeout", 1, pkt_n);
        chk("timeout len", 16'h0003, last_len);
        start(mk(6'b100001, 16'h0064));
        send(1'b0, 10, 8'h60);
        idle(5);
        chk("full", 1, pkt_n);
        chk("full len", 16'h0008, last_len);
        start(mk(6'b100001, 16'h0064));
        send(1'b0, 2, 8'h11);
        idle(30);
        repeat (3) send(1'b0, 1, 8'h2b);
        idle(40);
        chk("escape done", 1, cmd_n);
        chk("escape pkt", 1, pkt_n);
        chk("escape len", 16'h0002, last_len);
        $display("packetize done %0d", err_total);
        // First SPI input owns the block
        start(mk(6'b110101, 16'h0000));
        send(1'b1, 1, 8'h5a);
        idle(5);
        chk("port", 2'h2, active_port);
        send(1'b0, 1, 8'h77);
        idle(5);
        chk("spi no pkt", 0, pkt_n);
        chk("spi bytes", 1, eng_q.size());
        chk("spi data", 8'h5a, eng_q[0]);
        chk("spi cts", 1'b0, cts_n);
        chk("spi out", 1'b1, host_tx_spi);
        chk("attention", 1'b1, attention_line_n);
        $display("ports done %0d", err_total);
        finish_test();
    end
endmodule

`default_nettype wire
